// *** core/scd_defines.vh ***
// Purpose: Shared constants of the sinc decimation chain.
// Assumes: sys_clk is the master clock at 100 MHz.
// Notes: Definitions only.
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH

// ----------------------------------------------------------------
// Rates
// ----------------------------------------------------------------
`define SCD_SYS_CLK_MHZ 100
`define SCD_MOD_DIV 4
`define SCD_AZ_DIV 8

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SCD_ACC_W 32
`define SCD_SUM_W 35
`define SCD_CODE_W 24
`define SCD_WORD_W 32

// ----------------------------------------------------------------
// Codes and limits
// ----------------------------------------------------------------
`define SCD_AVG_ON_SEL 3'h4
`define SCD_POS_FULL 24'h7fffff
`define SCD_NEG_FULL 24'h800000
`define SCD_FMT_16 2'h0
`define SCD_FMT_24 2'h1
`define SCD_FMT_32Z 2'h2
`define SCD_FMT_32S 2'h3
`define SCD_SCALE_SH 21

`endif

// *** core/scd_cubic.v ***
// Purpose: Third-order sinc integrate-and-dump stage.
// Assumes: One sample per in_en pulse.
// Notes: Integrators wrap on purpose; the combs recover the true sum.
`default_nettype none
`include "scd_defines.vh"

module scd_cubic
(
	input wire sys_clk, // master clock
	input wire reset_n, // async reset, active low
	input wire clear, // synchronous restart
	input wire in_en, // one modulator sample this cycle
	input wire signed [2:0] in_val, // -2..+2
	input wire [3:0] ratio_log, // log2 of the decimation ratio
	output reg out_valid, // one-cycle pulse per output
	output reg signed [`SCD_ACC_W-1:0] out_val // comb output
);

	reg signed [`SCD_ACC_W-1:0] int1_q, int2_q, int3_q;
	reg signed [`SCD_ACC_W-1:0] dly1_q, dly2_q, dly3_q;
	reg [8:0] phase_q;
	wire [8:0] last_phase;
	wire signed [`SCD_ACC_W-1:0] in_ext, c1, c2, c3;
	wire signed [`SCD_ACC_W-1:0] n1, n2, n3;

	assign last_phase = 9'h1ff >> (4'h9 - ratio_log);
	assign in_ext = {{(`SCD_ACC_W-3){in_val[2]}}, in_val};
	assign n1 = int1_q + in_ext;
	assign n2 = int2_q + n1;
	assign n3 = int3_q + n2;
	assign c1 = n3 - dly1_q;
	assign c2 = c1 - dly2_q;
	assign c3 = c2 - dly3_q;

	// ------------------------------------------------------------
	// Integrators, decimator and combs
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			int1_q <= 32'h0;
			int2_q <= 32'h0;
			int3_q <= 32'h0;
			dly1_q <= 32'h0;
			dly2_q <= 32'h0;
			dly3_q <= 32'h0;
			phase_q <= 9'h0;
			out_valid <= 1'b0;
			out_val <= 32'h0;
		end
		else if (clear)
		begin
			int1_q <= 32'h0;
			int2_q <= 32'h0;
			int3_q <= 32'h0;
			dly1_q <= 32'h0;
			dly2_q <= 32'h0;
			dly3_q <= 32'h0;
			phase_q <= 9'h0;
			out_valid <= 1'b0;
			out_val <= 32'h0;
		end
		else
		begin
			out_valid <= 1'b0;
			if (in_en)
			begin
				int1_q <= n1;
				int2_q <= n2;
				int3_q <= n3;
				if (phase_q == last_phase)
				begin
					phase_q <= 9'h0;
					dly1_q <= n3;
					dly2_q <= c1;
					dly3_q <= c2;
					out_val <= c3;
					out_valid <= 1'b1;
				end
				else
				begin
					phase_q <= phase_q + 9'h1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// *** core/scd_decimator.v ***
// Purpose: One channel of sinc3 plus sinc1 decimation with output coding.
// Assumes: sys_clk is the master clock; modulator samples arrive as a
//   four-bit thermometer code, valid on each modulator sample tick.
// Notes: Changing oversample_select restarts the chain.
//
// Overview of operation
// - Third-order sinc by cubic ratio, then averaging of consecutive outputs.
// - Modulator output is sampled once per modulator sample clock period.
// - Averaging stage works only when total ratio exceeds 512.
// - Select codes map to ratios 32/1 up to 512/8.
// - Settling equals three cubic ratios plus (average ratio-1) cubic ratios.
// - Resolution is 17, 20, 23 or 24 bits by select code only.
// - Unused low bits are zero, result stays left justified.
// - Unsettled results are dropped after restart or ratio change; after hard reset at select 0 data-ready follows the first cubic output.
// - After settling, one data-ready per output rate period.
// - Input to output latency equals the settling time.
// - Result is 24-bit two's complement.
// - Result repacked into 16, 24 or 32 bit words by format setting.
// - Positive overrange clamps to 7fffff, then unused low bits read zero (7fff80 at 17 bits).
// - Negative overrange clamps to 800000.
// - DC code is input over reference times 2^23 times gain times 1.5.
// - With external select low, internal reference feeds all channels.
// - With external select high, reference pins form a differential input.
// - Reference buffer auto-zero runs synchronously to master clock.
// - Hard reset clears filters and buffers; result reads zero.
`default_nettype none
`include "scd_defines.vh"

module scd_decimator
(
	input wire sys_clk, // master clock, 100 MHz
	input wire reset_n, // async hard reset, active low
	input wire restart, // pulse, restarts conversion
	input wire [3:0] quant_thermo, // quantizer thermometer code
	input wire [2:0] oversample_select, // ratio select
	input wire [1:0] output_word_format, // word format select
	input wire ext_reference_select, // 1 = external reference
	output wire mod_sample_tick, // modulator sample pulse
	output reg data_ready, // one-cycle pulse per settled sample
	output reg [23:0] sample_data_q, // 24-bit result
	output reg [31:0] data_word_q, // repacked output word
	output wire [4:0] resolution_bits, // effective resolution
	output reg int_reference_en_q, // internal reference drives channels
	output reg ext_reference_in_q, // reference pins are an input
	output reg autozero_phase_q // reference buffer auto-zero phase
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function [3:0] cubic_log;
		input [2:0] sel;
		begin
			cubic_log = (sel > 3'h4) ? 4'h9 : (4'h5 + {1'b0, sel});
		end
	endfunction

	function [1:0] avg_log;
		input [2:0] sel;
		begin
			avg_log = (sel > `SCD_AVG_ON_SEL) ? (sel[1:0] - 2'h0) : 2'h0;
		end
	endfunction

	function [4:0] res_of;
		input [2:0] sel;
		begin
			case (sel)
				3'h0: res_of = 5'd17;
				3'h1: res_of = 5'd20;
				3'h2: res_of = 5'd23;
				default: res_of = 5'd24;
			endcase
		end
	endfunction

	function signed [2:0] thermo_val;
		input [3:0] t;
		begin
			thermo_val = $signed({1'b0, 2'b0}) + $signed({1'b0, t[0]})
				+ $signed({1'b0, t[1]}) + $signed({1'b0, t[2]})
				+ $signed({1'b0, t[3]}) - 3'sd2;
		end
	endfunction

	// ------------------------------------------------------------
	// Modulator sample divider and auto-zero divider
	// ------------------------------------------------------------
	localparam integer MOD_LAST = `SCD_MOD_DIV - 1;
	localparam integer AZ_LAST = `SCD_AZ_DIV - 1;
	reg [7:0] mod_cnt_q;
	reg [7:0] az_cnt_q;
	assign mod_sample_tick = (mod_cnt_q == MOD_LAST[7:0]);

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mod_cnt_q <= 8'h0;
			az_cnt_q <= 8'h0;
			autozero_phase_q <= 1'b0;
			int_reference_en_q <= 1'b1;
			ext_reference_in_q <= 1'b0;
		end
		else
		begin
			mod_cnt_q <= mod_sample_tick ? 8'h0 : mod_cnt_q + 8'h1;
			// The buffer chops on the master clock so its ripple stays
			// correlated with the modulator and folds out of band.
			if (az_cnt_q == AZ_LAST[7:0])
			begin
				az_cnt_q <= 8'h0;
				autozero_phase_q <= ~autozero_phase_q;
			end
			else
			begin
				az_cnt_q <= az_cnt_q + 8'h1;
			end
			int_reference_en_q <= ~ext_reference_select;
			ext_reference_in_q <= ext_reference_select;
		end
	end

	// ------------------------------------------------------------
	// Restart on request or ratio change
	// ------------------------------------------------------------
	reg [2:0] sel_q;
	wire chain_clear;
	wire [3:0] r_log;
	wire [1:0] a_log;
	wire [3:0] a_ratio;
	assign chain_clear = restart | (sel_q != oversample_select);
	assign r_log = cubic_log(oversample_select);
	assign a_log = avg_log(oversample_select);
	assign a_ratio = 4'h1 << a_log;
	assign resolution_bits = res_of(oversample_select);

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sel_q <= 3'h0;
		end
		else
		begin
			sel_q <= oversample_select;
		end
	end

	// ------------------------------------------------------------
	// Third-order stage
	// ------------------------------------------------------------
	wire cub_valid;
	wire signed [`SCD_ACC_W-1:0] cub_val;

	scd_cubic u_cubic
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clear(chain_clear),
		.in_en(mod_sample_tick),
		.in_val(thermo_val(quant_thermo)),
		.ratio_log(r_log),
		.out_valid(cub_valid),
		.out_val(cub_val)
	);

	// ------------------------------------------------------------
	// Averaging stage and settling gate
	// ------------------------------------------------------------
	reg signed [`SCD_ACC_W-1:0] hist_q [0:7];
	reg [2:0] ptr_q;
	reg signed [`SCD_SUM_W-1:0] sum_q;
	reg [3:0] wait_q;
	reg fin_valid_q;
	wire signed [`SCD_SUM_W-1:0] sum_d;
	wire [2:0] old_idx;
	integer i;
	assign old_idx = ptr_q - a_ratio[2:0];
	assign sum_d = sum_q + {{3{cub_val[31]}}, cub_val}
		- {{3{hist_q[old_idx][31]}}, hist_q[old_idx]};

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (i = 0; i < 8; i = i + 1)
				hist_q[i] <= 32'h0;
			ptr_q <= 3'h0;
			sum_q <= 35'h0;
			wait_q <= 4'h0;
			fin_valid_q <= 1'b0;
		end
		else if (chain_clear)
		begin
			for (i = 0; i < 8; i = i + 1)
				hist_q[i] <= 32'h0;
			ptr_q <= 3'h0;
			sum_q <= 35'h0;
			// The (A+2)th cubic output lands at 3R+(A-1)R samples.
			wait_q <= a_ratio + 4'h1;
			fin_valid_q <= 1'b0;
		end
		else
		begin
			fin_valid_q <= 1'b0;
			if (cub_valid)
			begin
				hist_q[ptr_q] <= cub_val;
				ptr_q <= ptr_q + 3'h1;
				sum_q <= sum_d;
				if (wait_q == 4'h0)
				begin
					wait_q <= a_ratio - 4'h1;
					fin_valid_q <= 1'b1;
				end
				else
				begin
					wait_q <= wait_q - 4'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Scaling, clamping and justification
	// ------------------------------------------------------------
	// Full scale of the modulator is +-2 per sample; the 1.5 transfer
	// gain means codes beyond 1/1.5 of that saturate.
	wire signed [`SCD_SUM_W-1:0] avg_val;
	wire signed [55:0] scaled;
	wire signed [55:0] tripled;
	reg [23:0] clamped;
	wire [23:0] res_mask;
	wire [23:0] coded;
	assign avg_val = sum_q >>> a_log;
	assign tripled = {{21{avg_val[34]}}, avg_val} * 56'sd3;
	assign scaled = (tripled <<< `SCD_SCALE_SH) >>> ({2'b0, r_log} * 6'd3);
	assign res_mask = 24'hffffff << (5'd24 - resolution_bits);
	assign coded = clamped & res_mask;

	always @*
	begin
		if (scaled > 56'sh7fffff)
			clamped = `SCD_POS_FULL;
		else if (scaled < -56'sh800000)
			clamped = `SCD_NEG_FULL;
		else
			clamped = scaled[23:0];
	end

	// ------------------------------------------------------------
	// Output buffer and word packing
	// ------------------------------------------------------------
	reg [31:0] packed_w;

	always @*
	begin
		case (output_word_format)
			`SCD_FMT_16: packed_w = {16'h0, coded[23:8]};
			`SCD_FMT_24: packed_w = {8'h0, coded};
			`SCD_FMT_32Z: packed_w = {coded, 8'h0};
			default: packed_w = {{8{coded[23]}}, coded};
		endcase
	end

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sample_data_q <= 24'h0;
			data_word_q <= 32'h0;
			data_ready <= 1'b0;
		end
		else if (chain_clear)
		begin
			data_ready <= 1'b0;
		end
		else
		begin
			data_ready <= fin_valid_q;
			if (fin_valid_q)
			begin
				sample_data_q <= coded;
				data_word_q <= packed_w;
			end
		end
	end

endmodule
`default_nettype wire

// *** test/scd_decimator_chk.sv ***
// Purpose: Port-level checker for one channel of the sinc decimation chain.
// Assumes: One clock domain, reset_n asynchronous and active low.
// Notes: Attached by the bind at the foot of this file.
`default_nettype none
`include "scd_defines.vh"
module scd_decimator_chk
(
	input wire logic sys_clk, // master clock
	input wire logic reset_n, // hard reset
	input wire logic restart, // restart pulse
	input wire logic [3:0] quant_thermo, // modulator code
	input wire logic [2:0] oversample_select, // ratio select
	input wire logic [1:0] output_word_format, // word format
	input wire logic ext_reference_select, // reference select
	input wire logic mod_sample_tick, // sample tick
	input wire logic data_ready, // new sample
	input wire logic [23:0] sample_data_q, // result
	input wire logic [31:0] data_word_q, // packed word
	input wire logic [4:0] resolution_bits, // resolution
	input wire logic int_reference_en_q, // internal reference on
	input wire logic ext_reference_in_q, // pins are an input
	input wire logic autozero_phase_q // auto-zero phase
);
	timeunit 1ns;
	timeprecision 100ps;
	// --------------------------------------------------------
	// Sequences
	// --------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence tick_gap_s;
		!mod_sample_tick [*3] ##1 mod_sample_tick;
	endsequence
	sequence az_gap_s;
		$stable(autozero_phase_q) [*7] ##1 $changed(autozero_phase_q);
	endsequence
	// --------------------------------------------------------
	// Properties
	// --------------------------------------------------------
	tick_period_a: assert property (mod_sample_tick |=> tick_gap_s)
		else $error("modulator tick spacing wrong");
	ready_pulse_a: assert property (data_ready |=> !data_ready [*8])
		else $error("data ready not a lone pulse");
	restart_quiet_a: assert property (restart |=> !data_ready [*8])
		else $error("data ready too soon after restart");
	data_hold_a: assert property (!data_ready && !$past(restart) |->
		$stable(sample_data_q))
		else $error("result changed without data ready");
	res_map_a: assert property (resolution_bits ==
		(oversample_select == 3'h0 ? 5'h11 : oversample_select == 3'h1 ? 5'h14 :
		oversample_select == 3'h2 ? 5'h17 : 5'h18))
		else $error("resolution does not match select");
	// The word was coded with the resolution of the edge before data ready;
	// the select may already have moved on by the time the pulse is seen.
	low_zero_a: assert property (data_ready |->
		(sample_data_q & ((24'h1 << (6'h18 - $past(resolution_bits))) - 24'h1)) == 24'h0)
		else $error("unused low bits not zero");
	word_24_a: assert property (data_ready &&
		$past(output_word_format) == `SCD_FMT_24 |-> data_word_q == {8'h0, sample_data_q})
		else $error("24-bit word wrong");
	word_16_a: assert property (data_ready &&
		$past(output_word_format) == `SCD_FMT_16 |->
		data_word_q == {16'h0, sample_data_q[23:8]})
		else $error("16-bit word wrong");
	ref_follow_a: assert property (
		ext_reference_in_q == $past(ext_reference_select) &&
		int_reference_en_q == !$past(ext_reference_select))
		else $error("reference outputs do not follow select");
	az_period_a: assert property ($changed(autozero_phase_q) |=> az_gap_s)
		else $error("auto-zero phase spacing wrong");
	reset_zero_a: assert property ($rose(reset_n) |->
		sample_data_q == 24'h0 && data_word_q == 32'h0)
		else $error("result not cleared by reset");
endmodule
bind scd_decimator scd_decimator_chk chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.restart(restart), .quant_thermo(quant_thermo), .oversample_select(oversample_select),
	.output_word_format(output_word_format), .ext_reference_select(ext_reference_select),
	.mod_sample_tick(mod_sample_tick), .data_ready(data_ready),
	.sample_data_q(sample_data_q), .data_word_q(data_word_q),
	.resolution_bits(resolution_bits), .int_reference_en_q(int_reference_en_q),
	.ext_reference_in_q(ext_reference_in_q), .autozero_phase_q(autozero_phase_q));
`default_nettype wire

// *** test/scd_mod_model.sv ***
// Purpose: Behavioural modulator quantizer feeding one decimator channel.
// Assumes: The level is held constant for a whole conversion.
// Notes: Changes only on the falling edge, so every tick sees a settled code.
`default_nettype none
module scd_mod_model
(
	input wire logic sys_clk, // master clock
	input wire logic reset_n, // hard reset
	input wire logic signed [2:0] level, // wanted value -2..+2
	output logic [3:0] quant_thermo // thermometer code
);
	timeunit 1ns;
	timeprecision 100ps;
	initial quant_thermo = 4'h3;
	always @(negedge sys_clk or negedge reset_n)
	begin : drive
		int n;
		n = level + 2;
		if (!reset_n)
			quant_thermo <= 4'h3;
		else
			quant_thermo <= 4'((1 << n) - 1);
	end
endmodule
`default_nettype wire

// *** test/test_sinc_decimator_output_coding.sv ***
// Purpose: Self-checking bench for one sinc decimation channel.
// Assumes: 100 MHz clock; the modulator model holds its level per run.
// Notes: A constant level v gives code v*3*2^21 before clamping and masking.
`default_nettype none
module test_sinc_decimator_output_coding;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 0, reset_n = 0, restart = 0, ext_reference_select = 0;
	logic [2:0] oversample_select = 3'h0;
	logic [1:0] output_word_format = 2'h1;
	logic signed [2:0] lvl = 3'sd0;
	logic [3:0] quant_thermo;
	logic mod_sample_tick, data_ready, int_reference_en_q, ext_reference_in_q, autozero_phase_q;
	logic [23:0] sample_data_q;
	logic [31:0] data_word_q;
	logic [4:0] resolution_bits;
	int fails = 0, cmp_count = 0, n;
	logic [31:0] fmt_exp [4] = '{32'h0000a000, 32'h00a00000, 32'ha0000000, 32'hffa00000};
	always #5 sys_clk = ~sys_clk;
	scd_mod_model pm (.sys_clk(sys_clk), .reset_n(reset_n), .level(lvl),
		.quant_thermo(quant_thermo));
	scd_decimator uut (.sys_clk(sys_clk), .reset_n(reset_n), .restart(restart),
		.quant_thermo(quant_thermo), .oversample_select(oversample_select),
		.output_word_format(output_word_format), .ext_reference_select(ext_reference_select),
		.mod_sample_tick(mod_sample_tick), .data_ready(data_ready),
		.sample_data_q(sample_data_q), .data_word_q(data_word_q),
		.resolution_bits(resolution_bits), .int_reference_en_q(int_reference_en_q),
		.ext_reference_in_q(ext_reference_in_q), .autozero_phase_q(autozero_phase_q));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Counts rising edges until data_ready, with a bound above the longest settling.
	task automatic wait_dr(output int cyc);
		cyc = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			cyc++;
		end
		while (data_ready !== 1'b1 && cyc < 25000);
		if (cyc >= 25000)
			check(32'h0, 32'h1);
	endtask
	task automatic settle(input logic [2:0] sel, input logic signed [2:0] lv,
		input logic [23:0] exp, input bit gap);
		int r, a, s;
		r = 32 << (sel > 4 ? 4 : sel);
		a = 1 << (sel > 4 ? sel - 4 : 0);
		s = 3 * r + (a - 1) * r;
		@(negedge sys_clk);
		oversample_select = sel;
		lvl = lv;
		restart = 1;
		@(negedge sys_clk);
		restart = 0;
		wait_dr(n);
		check(n >= 4 * s - 4 && n <= 4 * s + 8, 1);
		check(sample_data_q, exp);
		check(resolution_bits, sel == 0 ? 17 : sel == 1 ? 20 : sel == 2 ? 23 : 24);
		if (gap)
		begin
			wait_dr(n);
			check(n, 4 * r * a);
			check(sample_data_q, exp);
		end
	endtask
	task automatic formats;
		for (int f = 0; f < 4; f++)
		begin
			@(negedge sys_clk);
			output_word_format = f;
			wait_dr(n);
			wait_dr(n);
			check(data_word_q, fmt_exp[f]);
		end
	endtask
	task automatic refs;
		for (int e = 1; e >= 0; e--)
		begin
			@(negedge sys_clk);
			ext_reference_select = e;
			@(negedge sys_clk);
			check(ext_reference_in_q, e);
			check(int_reference_en_q, !e);
		end
	endtask
	task automatic mid_reset;
		@(negedge sys_clk);
		reset_n = 0;
		@(negedge sys_clk);
		check(sample_data_q, 0);
		check(data_word_q, 0);
		check({data_ready, int_reference_en_q}, 1);
		oversample_select = 3'h0;
		@(negedge sys_clk);
		reset_n = 1;
		settle(1, 0, 24'h0, 1);
	endtask
	initial
	begin
		repeat (5) @(negedge sys_clk);
		check(int_reference_en_q, 1);
		reset_n = 1;
		for (int s = 0; s < 8; s++)
			settle(s, 1, 24'h600000, s < 6);
		settle(0, 2, 24'h7fff80, 0);
		settle(0, -2, 24'h800000, 0);
		settle(3, 2, 24'h7fffff, 0);
		settle(3, -2, 24'h800000, 0);
		settle(0, -1, 24'ha00000, 1);
		formats();
		refs();
		mid_reset();
		stop_test();
	end
	initial
	begin
		#950000;
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
